// >>> shared/pin_state_pkg.sv
package pin_state_pkg;

  localparam int unsigned NUM_PINS = 8;

  // Operating modes of the device as seen by the pad control.
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_SLEEP  = 3'b001,
    MODE_STOP   = 3'b010,
    MODE_WATCH  = 3'b011
  } power_mode_e;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PULLUP    = 8'h04;
  localparam logic [7:0] OFS_EXTINT_EN = 8'h08;
  localparam logic [7:0] OFS_CMP_EN    = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;
  localparam logic [7:0] OFS_PIN_IN    = 8'h1c;

  // Control register field positions.
  localparam int unsigned CTRL_MODE_LSB   = 0;
  localparam int unsigned CTRL_FLOAT_BIT  = 4;
  localparam int unsigned CTRL_I2C_WK_BIT = 5;

  // Interrupt status bit positions.
  localparam int unsigned IRQ_EXTINT_BIT = 0;
  localparam int unsigned IRQ_CMP_BIT    = 1;
  localparam int unsigned IRQ_I2C_BIT    = 2;
  localparam int unsigned IRQ_BITS       = 3;

  // Reset values.
  localparam logic [5:0] CTRL_RESET     = 6'h00;
  localparam logic [7:0] PULLUP_RESET   = 8'h00;
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> core/pad_cell_ctrl.sv
`timescale 1ns/1ps
module pad_cell_ctrl
  import pin_state_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic in_reset,
  input  wire logic standby,
  input  wire logic float_sel,
  input  wire logic pullup_en,
  input  wire logic port_out,
  input  wire logic port_oe,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pullup,
  output logic      pad_ie,
  output logic      core_in,
  output logic      pin_sync
);

  logic held_out_q;
  logic held_oe_q;
  logic sync1_q;
  logic sync2_q;

  // Capture the drive state while awake so it can be frozen in standby.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_out_q <= 1'b0;
      held_oe_q  <= 1'b0;
    end else if (!standby) begin
      held_out_q <= port_out;
      held_oe_q  <= port_oe;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  always_comb begin
    if (in_reset) begin
      pad_out = 1'b0;
      pad_oe  = 1'b0;
      pad_ie  = 1'b1;
    end else if (standby) begin
      pad_out = held_out_q;
      pad_oe  = held_oe_q & ~float_sel;
      pad_ie  = 1'b0;
    end else begin
      pad_out = port_out;
      pad_oe  = port_oe;
      pad_ie  = 1'b1;
    end
  end

  assign pad_pullup = pullup_en;
  // The interrupt detector needs the pin even while the core path is blocked.
  assign pin_sync   = sync2_q;
  // Reset and standby both keep pin activity from reaching the core.
  assign core_in = sync2_q & ~standby & ~in_reset;

endmodule

// >>> core/standby_pin_state_control.sv
`timescale 1ns/1ps
// Contract
// - In stop and watch modes a pin holds its last output when the float select is clear and floats when set, inputs blocked.
// - A blocked input keeps pin activity away from peripherals and port reads.
// - Floating pins keep their programmed pull-up setting.
// - During reset pins float with input buffers enabled while peripherals ignore the input.
// - A pin used as an output port takes the same standby and reset state as any other.
// - External interrupt edges still pass in standby when that interrupt is enabled.
// - Comparator inputs still reach the comparator in standby and can interrupt when enabled.
// - The comparator output keeps operating in stop and watch modes.
// - The I2C pins can wake the processor from stop or watch when the wake function is enabled.
// - These pin states apply to pins configured as general-purpose ports.
module standby_pin_state_control
  import pin_state_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [NUM_PINS-1:0] port_out,
  input  wire logic [NUM_PINS-1:0] port_oe,
  input  wire logic                cmp_out,
  input  wire logic                i2c_scl_out_low,
  input  wire logic                i2c_sda_out_low,
  input  wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0]      pad_out,
  output logic [NUM_PINS-1:0]      pad_oe,
  output logic [NUM_PINS-1:0]      pad_pullup,
  output logic [NUM_PINS-1:0]      pad_ie,
  input  wire logic                cmp_analog_in,
  input  wire logic                scl_in,
  output logic                     scl_out,
  output logic                     scl_oe,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  output logic [NUM_PINS-1:0]      core_in,
  output logic                     cmp_result,
  output logic                     cmp_pin_out,
  output logic                     wake_req,
  output logic                     irq
);

  logic [5:0]          ctrl_q;
  logic [NUM_PINS-1:0] pullup_q;
  logic [NUM_PINS-1:0] extint_en_q;
  logic                cmp_en_q;
  logic [IRQ_BITS-1:0] irq_stat_q;
  logic [IRQ_BITS-1:0] irq_mask_q;
  logic [NUM_PINS-1:0] extint_prev_q;
  logic                cmp_s1_q;
  logic                cmp_s2_q;
  logic                cmp_prev_q;
  logic                scl_s1_q;
  logic                scl_s2_q;
  logic                sda_s1_q;
  logic                sda_s2_q;
  logic                sda_prev_q;
  logic                aw_seen_q;
  logic                w_seen_q;
  logic [7:0]          awaddr_q;
  logic [31:0]         wdata_q;
  logic                wstrb0_q;
  logic                in_reset;
  logic                standby;
  logic                float_sel;
  logic                i2c_wake_en;
  logic [NUM_PINS-1:0] ext_edge;
  logic                cmp_edge;
  logic                i2c_start;
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clr;
  logic                wr_go;
  logic [NUM_PINS-1:0] raw_in;
  power_mode_e         mode;

  assign mode        = power_mode_e'(ctrl_q[CTRL_MODE_LSB +: 3]);
  assign in_reset    = ~aresetn;
  assign standby     = (mode == MODE_STOP) || (mode == MODE_WATCH);
  assign float_sel   = ctrl_q[CTRL_FLOAT_BIT];
  assign i2c_wake_en = ctrl_q[CTRL_I2C_WK_BIT];

  // Every port pin uses the same cell whatever it is wired to, so output-only use changes nothing.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pad
    pad_cell_ctrl u_pad (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .in_reset   (in_reset),
      .standby    (standby),
      .float_sel  (float_sel),
      .pullup_en  (pullup_q[i]),
      .port_out   (port_out[i]),
      .port_oe    (port_oe[i]),
      .pad_in     (pad_in[i]),
      .pad_out    (pad_out[i]),
      .pad_oe     (pad_oe[i]),
      .pad_pullup (pad_pullup[i]),
      .pad_ie     (pad_ie[i]),
      .core_in    (core_in[i]),
      .pin_sync   (raw_in[i])
    );
  end

  // External interrupt path bypasses the blocked gate; it reads the raw synchronised pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      extint_prev_q <= '0;
    end else begin
      extint_prev_q <= raw_in;
    end
  end

  assign ext_edge = (raw_in ^ extint_prev_q) & extint_en_q;

  // Comparator sees the analog pin regardless of standby blocking.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_s1_q   <= 1'b0;
      cmp_s2_q   <= 1'b0;
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_s1_q   <= cmp_analog_in;
      cmp_s2_q   <= cmp_s1_q;
      cmp_prev_q <= cmp_s2_q;
    end
  end

  assign cmp_result  = cmp_s2_q & ~in_reset;
  assign cmp_edge    = cmp_en_q & (cmp_s2_q ^ cmp_prev_q);
  assign cmp_pin_out = in_reset ? 1'b0 : cmp_out;

  // I2C pins: open drain, wake on a start condition (SDA falls while SCL high).
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s1_q   <= 1'b1;
      scl_s2_q   <= 1'b1;
      sda_s1_q   <= 1'b1;
      sda_s2_q   <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_s1_q   <= scl_in;
      scl_s2_q   <= scl_s1_q;
      sda_s1_q   <= sda_in;
      sda_s2_q   <= sda_s1_q;
      sda_prev_q <= sda_s2_q;
    end
  end

  assign i2c_start = standby & i2c_wake_en & scl_s2_q & sda_prev_q & ~sda_s2_q;
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;
  assign scl_oe    = ~in_reset & ~standby & i2c_scl_out_low;
  assign sda_oe    = ~in_reset & ~standby & i2c_sda_out_low;

  assign wake_req = standby & ((|ext_edge) | cmp_edge | i2c_start);

  // Interrupt status: set wins over a write-one-to-clear in the same cycle.
  assign irq_set = {i2c_start, cmp_edge, |ext_edge};
  assign irq_clr = (wr_go && awaddr_q == OFS_IRQ_STAT && wstrb0_q) ? wdata_q[IRQ_BITS-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // AXI4-Lite write: address and data in either order, response after both.
  assign s_axi_awready = ~aw_seen_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_seen_q & ~s_axi_bvalid;
  assign wr_go         = aw_seen_q & w_seen_q & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_seen_q    <= 1'b0;
      w_seen_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb0_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_seen_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_seen_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_seen_q    <= 1'b0;
        w_seen_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == OFS_CTRL || awaddr_q == OFS_PULLUP || awaddr_q == OFS_EXTINT_EN ||
            awaddr_q == OFS_CMP_EN || awaddr_q == OFS_IRQ_STAT || awaddr_q == OFS_IRQ_MASK) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= CTRL_RESET;
      pullup_q    <= PULLUP_RESET;
      extint_en_q <= ENABLE_RESET;
      cmp_en_q    <= 1'b0;
      irq_mask_q  <= IRQ_MASK_RESET;
    end else if (wr_go && wstrb0_q) begin
      if (awaddr_q == OFS_CTRL) begin
        ctrl_q <= wdata_q[5:0];
      end else if (awaddr_q == OFS_PULLUP) begin
        pullup_q <= wdata_q[7:0];
      end else if (awaddr_q == OFS_EXTINT_EN) begin
        extint_en_q <= wdata_q[7:0];
      end else if (awaddr_q == OFS_CMP_EN) begin
        cmp_en_q <= wdata_q[0];
      end else if (awaddr_q == OFS_IRQ_MASK) begin
        irq_mask_q <= wdata_q[IRQ_BITS-1:0];
      end
    end
  end

  // AXI4-Lite read: one cycle after the address is taken.
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == OFS_CTRL) begin
        s_axi_rdata <= {26'h0, ctrl_q};
      end else if (s_axi_araddr == OFS_PULLUP) begin
        s_axi_rdata <= {24'h0, pullup_q};
      end else if (s_axi_araddr == OFS_EXTINT_EN) begin
        s_axi_rdata <= {24'h0, extint_en_q};
      end else if (s_axi_araddr == OFS_CMP_EN) begin
        s_axi_rdata <= {31'h0, cmp_en_q};
      end else if (s_axi_araddr == OFS_STATUS) begin
        s_axi_rdata <= {30'h0, cmp_result, standby};
      end else if (s_axi_araddr == OFS_IRQ_STAT) begin
        s_axi_rdata <= {29'h0, irq_stat_q};
      end else if (s_axi_araddr == OFS_IRQ_MASK) begin
        s_axi_rdata <= {29'h0, irq_mask_q};
      end else if (s_axi_araddr == OFS_PIN_IN) begin
        s_axi_rdata <= {24'h0, core_in};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> tb/pin_state_chk.sv
`timescale 1ns/1ps
module pin_state_chk
  import pin_state_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe,
  input wire logic       cmp_out,
  input wire logic       i2c_scl_out_low,
  input wire logic       i2c_sda_out_low,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_ie,
  input wire logic       scl_oe,
  input wire logic       sda_oe,
  input wire logic [7:0] core_in,
  input wire logic       cmp_pin_out,
  input wire logic       cmp_analog_in,
  input wire logic       sda_in,
  input wire logic       wake_req
);
  logic [1:0] up_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Edges since reset release, saturating at three, because the synchronisers need that long to refill.
  always_ff @(posedge aclk) up_q <= !aresetn ? 2'h0 : up_q + {1'b0, up_q != 2'h3};
  pad_hold_a: assert property (pad_ie == '0 && $past(pad_ie) == '0
    |-> $stable(pad_out) && $stable(pad_oe)) else $error("pad drive changed in standby");
  core_zero_a: assert property (pad_ie == '0 && $past(pad_ie) == '0 && $past(pad_ie, 2) == '0
    |-> core_in == '0) else $error("blocked input reached core");
  core_sync_a: assert property (up_q == 2'h3 && pad_ie == '1 && $past(pad_ie) == '1 && $past(pad_ie, 2) == '1
    |-> core_in == $past(pad_in, 2)) else $error("core input does not follow pad");
  pad_pass_a: assert property (up_q == 2'h3 && pad_ie == '1 |-> pad_oe == port_oe
    && (pad_out & port_oe) == (port_out & port_oe)) else $error("pad does not follow port");
  i2c_drive_a: assert property (up_q == 2'h3 |-> scl_oe == (i2c_scl_out_low && pad_ie != '0)
    && sda_oe == (i2c_sda_out_low && pad_ie != '0)) else $error("bus pin drive wrong");
  cmp_pass_a: assert property (up_q == 2'h3 |-> cmp_pin_out == cmp_out)
    else $error("comparator output not passed");
  // Each wake source needs an edge that crossed its synchroniser; steady inputs can never wake.
  wake_cause_a: assert property (up_q == 2'h3 && $past(pad_in, 2) == $past(pad_in, 3)
    && $past(cmp_analog_in, 2) == $past(cmp_analog_in, 3) && $past(sda_in, 2) == $past(sda_in, 3)
    |-> !wake_req) else $error("wake request without a pin edge");
  wake_stby_a: assert property (wake_req |-> pad_ie == '0)
    else $error("wake request outside standby");
endmodule

// >>> tb/pin_partner.sv
`timescale 1ns/1ps
// A pad nobody drives or pulls toggles each cycle, so a floating input never looks like a steady level.
module pin_partner
  import pin_state_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  input  wire logic       scl_out,
  input  wire logic       scl_oe,
  input  wire logic       sda_out,
  input  wire logic       sda_oe,
  input  wire logic       scl_lo,
  input  wire logic       sda_lo,
  output logic [7:0]      pad_in,
  output logic            scl_in,
  output logic            sda_in
);
  logic [7:0] fl_q = '0;
  always @(posedge aclk) fl_q <= ~fl_q;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | (~ext_en & (pad_pullup | fl_q))));
  // Both bus lines are open drain with a pull-up; either side may pull low.
  assign scl_in = !((scl_oe && !scl_out) || scl_lo);
  assign sda_in = !((sda_oe && !sda_out) || sda_lo);
endmodule

// >>> tb/standby_pin_state_control_test.sv
`timescale 1ns/1ps
module standby_pin_state_control_test
  import pin_state_pkg::*;
;
  typedef struct packed {
    logic [5:0] ctrl;
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] ie;
    logic [7:0] core;
  } row_s;
  // The port asks for 0f/a5 after each mode change; a held pad still shows the f0/5a from before it.
  localparam row_s ROWS [6] = '{
    '{6'h00, 8'h0f, 8'ha5, 8'hff, 8'h05}, '{6'h11, 8'h0f, 8'ha5, 8'hff, 8'h05},
    '{6'h02, 8'hf0, 8'h5a, 8'h00, 8'h00}, '{6'h12, 8'h00, 8'h5a, 8'h00, 8'h00},
    '{6'h03, 8'hf0, 8'h5a, 8'h00, 8'h00}, '{6'h13, 8'h00, 8'h5a, 8'h00, 8'h00}};
  localparam logic [7:0] RST_OFS [4] = '{OFS_CTRL, OFS_PULLUP, OFS_EXTINT_EN, OFS_IRQ_MASK};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cmp_out, cmp_analog_in;
  logic        i2c_scl_out_low, i2c_sda_out_low, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  logic        cmp_result, cmp_pin_out, wake_req, irq, scl_lo, sda_lo;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, port_out, port_oe, pad_in, pad_out, pad_oe, pad_pullup;
  logic [7:0]  pad_ie, core_in, ext_en, ext_val;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          errors, n_checks, cyc, wakes, w0;

  standby_pin_state_control uut (.*);
  pin_partner far (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .ext_en(ext_en),
    .ext_val(ext_val), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .scl_lo(scl_lo),
    .sda_lo(sda_lo), .pad_in(pad_in), .scl_in(scl_in), .sda_in(sda_in));

  always #25 aclk = ~aclk;

  task automatic close_out();
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Handshakes are sampled at the falling edge, where nothing the bench drives can still be moving.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      hb = s_axi_bvalid;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic       ha, hr;
    logic [7:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge aclk);
      ha = s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    chk(d, e);
    chk({6'h0, r}, {6'h0, er});
  endtask

  task automatic irq_is(input logic e);
    @(negedge aclk);
    chk({7'h0, irq}, {7'h0, e});
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (wake_req === 1'b1) wakes++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cmp_out, cmp_analog_in, scl_lo, sda_lo} = '0;
    {s_axi_awaddr, s_axi_araddr, port_out, port_oe, ext_en, ext_val, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, i2c_scl_out_low, i2c_sda_out_low} = '1;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (RST_OFS[i]) rchk(RST_OFS[i], 8'h00, RESP_OKAY);
    rchk(8'h20, 8'h00, RESP_SLVERR);
    wr(OFS_PULLUP, 32'h3c);
    foreach (ROWS[i]) begin
      port_out <= 8'h5a;
      port_oe <= 8'hf0;
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, {26'h0, ROWS[i].ctrl});
      port_out <= 8'ha5;
      port_oe <= 8'h0f;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      chk(pad_oe, ROWS[i].oe);
      chk(pad_out & ROWS[i].oe, ROWS[i].out & ROWS[i].oe);
      chk(pad_ie, ROWS[i].ie);
      chk(core_in & (ROWS[i].ie != 8'h00 ? 8'h0f : 8'hff), ROWS[i].core);
      chk(pad_pullup, 8'h3c);
      @(posedge aclk);
    end
    // Pin 0 turns into an input driven from outside, then every wake source fires in stop mode.
    {i2c_scl_out_low, i2c_sda_out_low} <= 2'h0;
    port_oe <= 8'h00;
    ext_en <= 8'h01;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_EXTINT_EN, 32'h1);
    wr(OFS_CMP_EN, 32'h1);
    wr(OFS_CTRL, 32'h22);
    w0 = wakes;
    ext_val <= 8'h01;
    repeat (6) @(posedge aclk);
    irq_is(1'b0);
    rchk(OFS_IRQ_STAT, 8'h01, RESP_OKAY);
    rchk(OFS_PIN_IN, 8'h00, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h7);
    irq_is(1'b1);
    wr(OFS_IRQ_STAT, 32'h1);
    irq_is(1'b0);
    cmp_analog_in <= 1'b1;
    cmp_out <= 1'b1;
    repeat (6) @(posedge aclk);
    irq_is(1'b1);
    rchk(OFS_STATUS, 8'h03, RESP_OKAY);
    chk({7'h0, cmp_pin_out}, 8'h01);
    sda_lo <= 1'b1;
    repeat (6) @(posedge aclk);
    rchk(OFS_IRQ_STAT, 8'h06, RESP_OKAY);
    chk(8'(wakes - w0), 8'h03);
    wr(OFS_IRQ_STAT, 32'h2);
    rchk(OFS_IRQ_STAT, 8'h04, RESP_OKAY);
    sda_lo <= 1'b0;
    port_oe <= 8'hff;
    port_out <= 8'hff;
    ext_en <= 8'h00;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(pad_oe, 8'h00);
    chk(pad_ie, 8'hff);
    chk(core_in, 8'h00);
    @(posedge aclk);
    aresetn <= 1'b1;
    foreach (RST_OFS[i]) rchk(RST_OFS[i], 8'h00, RESP_OKAY);
    repeat (3) @(posedge aclk);
    rchk(OFS_PIN_IN, 8'hff, RESP_OKAY);
    close_out();
  end
endmodule

bind standby_pin_state_control pin_state_chk chk (.*);
